// ### core/nrz_rz_defines.svh
// Constants shared by the NRZ to RZ encoder and its measurement buffer.
// Assumes a single 10 MHz clock domain; all counts are in clock cycles.
`ifndef NRZ_RZ_DEFINES_SVH
`define NRZ_RZ_DEFINES_SVH

// Clock period of clk_in in ns
`define CLK_PERIOD_NS 100

// Width of bit-time counts and of measurement words
`define BT_W 16

// Default bit time; nothing reads it, the period after reset comes from bit_time_cfg_in
`define BT_DEFAULT 16'h0064

// Shortest period the pulse timer runs: one high cycle, one low cycle
`define BT_MIN 16'h0002

// Increment and saturation value of the gap counter
`define BT_ONE 16'h0001
`define BT_SAT 16'hffff

// Words held by the measurement buffer
`define MEAS_DEPTH 16

`endif

// ### core/nrz_rz_pkg.sv
// Types of the NRZ to RZ encoder.
// Assumes nrz_rz_defines.svh is on the include path.
`include "nrz_rz_defines.svh"

package nrz_rz_pkg;

    // Which external cell input carries the NRZ stream
    typedef enum logic {
        SRC_INPUT_A,
        SRC_INPUT_B
    } src_sel_t;

    // Whole state of the encoder top
    typedef struct packed {
        logic a_meta;
        logic a_sync;
        logic b_meta;
        logic b_sync;
        logic nrz_prev;
        logic [`BT_W-1:0] phase;
        logic [`BT_W-1:0] period;
        logic pulse;
        logic rz_out;
        logic [`BT_W-1:0] gap_cnt;
        logic seen_edge;
        logic [`BT_W-1:0] min_bt;
        logic min_valid;
        logic pend;
        logic [`BT_W-1:0] pend_data;
        logic overflow;
    } encoder_state_t;

endpackage

// ### core/meas_fifo.sv
// First-in first-out buffer with a registered head word.
// Assumes one clock; push and pop use valid/ready, a word moves when both are high.
module meas_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 16
) (
    // Clock and reset
    input wire logic clk_in,
    input wire logic rst_n_in,
    // Filling side
    input wire logic push_valid_in,
    input wire logic [WIDTH-1:0] push_data_in,
    output logic push_ready_out,
    // Draining side
    output logic pop_valid_out,
    output logic [WIDTH-1:0] pop_data_out,
    input wire logic pop_ready_in
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam int CW = $clog2(DEPTH + 1);
    localparam logic [CW-1:0] FULL_CNT = CW'(DEPTH);
    localparam logic [AW-1:0] LAST_PTR = AW'(DEPTH - 1);

    typedef struct packed {
        logic [AW-1:0] wr;
        logic [AW-1:0] rd;
        logic [CW-1:0] count;
        logic head_valid;
        logic [WIDTH-1:0] head;
    } fifo_state_t;

    fifo_state_t st_r;
    fifo_state_t st_nxt;
    logic [WIDTH-1:0] mem [DEPTH];
    logic push;
    logic load;

    // The head register keeps the output off the memory read mux
    assign push_ready_out = (st_r.count != FULL_CNT);
    assign push = push_valid_in & push_ready_out;
    assign load = (st_r.count != '0) & (~st_r.head_valid | pop_ready_in);
    assign pop_valid_out = st_r.head_valid;
    assign pop_data_out = st_r.head;

    always_comb begin
        st_nxt = st_r;
        if (push) begin
            st_nxt.wr = (st_r.wr == LAST_PTR) ? '0 : st_r.wr + AW'(1);
        end
        if (load) begin
            st_nxt.head = mem[st_r.rd];
            st_nxt.head_valid = 1'b1;
            st_nxt.rd = (st_r.rd == LAST_PTR) ? '0 : st_r.rd + AW'(1);
        end else if (pop_ready_in) begin
            st_nxt.head_valid = 1'b0;
        end
        unique case ({push, load})
            2'b10: st_nxt.count = st_r.count + CW'(1);
            2'b01: st_nxt.count = st_r.count - CW'(1);
            default: st_nxt.count = st_r.count;
        endcase
    end

    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    always_ff @(posedge clk_in) begin
        if (push) begin
            mem[st_r.wr] <= push_data_in;
        end
    end

endmodule

// ### core/nrz_to_rz_encoder.sv
// NRZ to RZ line encoder: a logic cell in AND-OR form gating the NRZ input
// with a half-bit pulse from a triggered timer, plus a bit-time capture unit
// whose measured gaps wait in a small buffer for a reader.
// Assumes both cell inputs are asynchronous pins and all control inputs come
// from logic on clk_in. Outputs reach the pin one register after the decision,
// three clock edges after the selected pin changes.
`include "nrz_rz_defines.svh"

// Contract
// RL1 - Source holds high for one, low for zero
// RL2 - One: high first half; zero: low throughout
// RL3 - Pulse high T/2, low rest of T
// RL4 - Timer triggered by the logic cell edges
// RL5 - NRZ taken from input A or B
// RL6 - Pulse reaches the cell internally, no pin
// RL7 - Cell combines NRZ and pulse AND-OR
// RL8 - Capture measures bit time, may set period
// RL9 - Result drives the dedicated cell output pin
// RL10 - Output is NRZ AND pulse, boundary aligned
// RL11 - Each trigger restarts the high half-period
module nrz_to_rz_encoder #(
    parameter int MEAS_DEPTH = `MEAS_DEPTH
) (
    // Clock and reset
    input wire logic clk_in,
    input wire logic rst_n_in,
    // External cell inputs
    input wire logic cell_input_a_in,
    input wire logic cell_input_b_in,
    // Configuration
    input wire nrz_rz_pkg::src_sel_t src_sel_in,
    input wire logic encode_enable_in,
    input wire logic [`BT_W-1:0] bit_time_cfg_in,
    input wire logic auto_period_in,
    input wire logic measure_restart_in,
    // Line output and timer view
    output logic cell_output_pin_out,
    output logic pulse_out,
    output logic [`BT_W-1:0] period_out,
    // Bit-time measurements
    output logic measure_valid_out,
    output logic [`BT_W-1:0] measure_data_out,
    input wire logic measure_ready_in,
    output logic measure_overflow_out
);
    import nrz_rz_pkg::*;

    encoder_state_t st_r;
    encoder_state_t st_nxt;

    logic nrz;
    logic trig;
    logic [`BT_W-1:0] period;
    logic [`BT_W-1:0] half;
    logic [`BT_W-1:0] pos;
    logic pulse;
    logic [`BT_W-1:0] interval;
    logic meas_event;
    logic fifo_ready;
    logic consumed;
    logic nrz_rise;
    logic nrz_fall;
    logic wrap;
    logic cell_data;
    logic cell_ref;
    logic cell_and;
    logic new_min;
    logic lost;

    // Selected, synchronised NRZ level; only the second flops are read here
    always_comb begin
        nrz = (src_sel_in == SRC_INPUT_A) ? st_r.a_sync : st_r.b_sync; // [RL5]
    end

    // Every NRZ edge is a bit boundary and triggers the timer. Moving the source
    // select while the two pins differ gives one false edge, so switch when idle.
    assign nrz_rise = nrz & ~st_r.nrz_prev;
    assign nrz_fall = ~nrz & st_r.nrz_prev;
    assign trig = nrz_rise | nrz_fall; // [RL4] [RL1]

    // Period comes from the measured minimum gap once one is known. The minimum
    // only ever falls, so a source that slows down needs a measurement restart.
    always_comb begin
        if (auto_period_in && st_r.min_valid) begin
            period = st_r.min_bt; // [RL8]
        end else begin
            period = bit_time_cfg_in;
        end
        // A period below two cycles cannot hold a high and a low half
        if (period < `BT_MIN) begin
            period = `BT_MIN;
        end
    end

    // Odd periods round the high half down
    assign half = period >> 1; // [RL3]

    // Last cycle of a bit; without a trigger the timer starts the next bit here
    assign wrap = (st_r.phase >= period - `BT_ONE);

    // Position in the current bit; a trigger forces the start of a bit, which
    // also clears any drift between the timer and the source
    always_comb begin
        if (trig) begin
            pos = '0; // [RL11]
        end else if (wrap) begin
            pos = '0;
        end else begin
            pos = st_r.phase + `BT_ONE;
        end
    end

    // Pulse stays internal and feeds the gate below directly; it is high for the
    // first half of every bit whether or not the bit is a one
    assign pulse = (pos < half); // [RL3] [RL6]

    // Data gates of the cell: the selected pin and the pulse as reference clock
    assign cell_data = nrz; // [RL5]
    assign cell_ref = pulse; // [RL6]

    // AND-OR function; the OR term has no second product in this use, so the
    // output is the product of data and reference with true polarity
    assign cell_and = cell_data & cell_ref; // [RL7] [RL10]

    // Gap between edges, counted in cycles, saturating on long idle runs
    // so that a long idle run never wraps into a short false bit time
    assign interval = (st_r.gap_cnt == `BT_SAT) ? `BT_SAT : st_r.gap_cnt + `BT_ONE;

    // First edge after reset or restart has no valid gap before it
    assign meas_event = trig & st_r.seen_edge;
    assign consumed = st_r.pend & fifo_ready;

    // A gap shorter than any seen so far becomes the bit-time estimate
    assign new_min = meas_event & (~st_r.min_valid | (interval < st_r.min_bt));

    // A gap is lost when the word before it still waits for room in the buffer
    assign lost = meas_event & st_r.pend & ~consumed;

    always_comb begin
        st_nxt = st_r;

        // Two-flop synchronisers for both pins; both always run, so a source
        // switch finds a settled level on the newly selected pin
        st_nxt.a_meta = cell_input_a_in;
        st_nxt.a_sync = st_r.a_meta;
        st_nxt.b_meta = cell_input_b_in;
        st_nxt.b_sync = st_r.b_meta;
        st_nxt.nrz_prev = nrz;

        // Half-bit pulse timer
        st_nxt.phase = pos;
        st_nxt.period = period;
        st_nxt.pulse = pulse;

        // Enable gates only the line; timer and capture keep running while low
        st_nxt.rz_out = encode_enable_in & cell_and; // [RL7] [RL10] [RL2]

        // Bit-time capture
        if (trig) begin
            st_nxt.gap_cnt = '0; // [RL8]
            st_nxt.seen_edge = 1'b1;
        end else begin
            st_nxt.gap_cnt = interval;
        end

        if (measure_restart_in) begin
            // Restart forgets the estimate; an edge now starts a new first gap
            st_nxt.min_valid = 1'b0;
            st_nxt.seen_edge = trig;
            st_nxt.overflow = 1'b0;
        end else if (new_min) begin
            // Shortest gap seen is one bit time; longer gaps are runs
            st_nxt.min_bt = interval; // [RL8]
            st_nxt.min_valid = 1'b1;
        end

        // One word waits for the buffer. A loss sets the flag even when a
        // restart clears it in the same cycle, so no dropped word goes unseen.
        if (lost) begin
            st_nxt.overflow = 1'b1; // [RL8]
        end else if (meas_event && !measure_restart_in) begin
            st_nxt.pend = 1'b1;
            st_nxt.pend_data = interval;
        end else if (consumed) begin
            st_nxt.pend = 1'b0;
        end
    end

    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    // Measurement buffer; a stalled reader fills it and then holds the word.
    // Words held: DEPTH in the buffer, one in its head and one pending; beyond
    // that a new gap sets the overflow flag instead of stalling the capture.
    meas_fifo #(
        .WIDTH(`BT_W),
        .DEPTH(MEAS_DEPTH)
    ) u_meas_fifo (
        .clk_in(clk_in),
        .rst_n_in(rst_n_in),
        .push_valid_in(st_r.pend),
        .push_data_in(st_r.pend_data),
        .push_ready_out(fifo_ready),
        .pop_valid_out(measure_valid_out),
        .pop_data_out(measure_data_out),
        .pop_ready_in(measure_ready_in)
    );

    // Registered drive of the dedicated pin, so no gate glitch reaches the link;
    // the pulse and period outputs let a user watch the timer
    assign cell_output_pin_out = st_r.rz_out; // [RL9]
    assign pulse_out = st_r.pulse;
    assign period_out = st_r.period;
    assign measure_overflow_out = st_r.overflow;

endmodule

// ### tb/nrz_rz_monitor.sv
// Port-level checks of the NRZ to RZ encoder, bound into every instance.
// Assumes one clock domain and the synchronous active-low reset.
`include "nrz_rz_defines.svh"
module nrz_rz_monitor #(
    parameter int MEAS_DEPTH = 16
) (
    // Clock, reset and pins
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic cell_input_a_in,
    input wire logic cell_input_b_in,
    // Configuration
    input wire nrz_rz_pkg::src_sel_t src_sel_in,
    input wire logic encode_enable_in,
    input wire logic [`BT_W-1:0] bit_time_cfg_in,
    input wire logic auto_period_in,
    input wire logic measure_restart_in,
    // Outputs and reader
    input wire logic cell_output_pin_out,
    input wire logic pulse_out,
    input wire logic [`BT_W-1:0] period_out,
    input wire logic measure_valid_out,
    input wire logic [`BT_W-1:0] measure_data_out,
    input wire logic measure_ready_in,
    input wire logic measure_overflow_out
);
    timeunit 1ns;
    timeprecision 1ns;
    import nrz_rz_pkg::*;
    logic [`BT_W-1:0] run_r;
    logic last_r;
    logic arm_r;
    default clocking @(posedge clk_in); endclocking
    default disable iff (!rst_n_in);
    // Run length ends one edge back; arming skips the run cut by a period change
    always_ff @(posedge clk_in) begin
        last_r <= pulse_out;
        run_r <= (pulse_out == last_r) ? run_r + `BT_ONE : `BT_ONE;
        if (!rst_n_in || $changed(period_out)) arm_r <= 1'b0;
        else if ($fell(pulse_out)) arm_r <= 1'b1;
    end
    a_rz_within_pulse: assert property (cell_output_pin_out |-> pulse_out)
        else $error("line high outside pulse");
    a_rz_follows_pin: assert property (cell_output_pin_out |-> $past(encode_enable_in) &&
        ($past(src_sel_in) == SRC_INPUT_B ? $past(cell_input_b_in, 3) : $past(cell_input_a_in, 3)))
        else $error("line high without enabled one");
    a_one_starts_high: assert property ($rose(cell_input_a_in) && src_sel_in == SRC_INPUT_A
        ##1 (src_sel_in == SRC_INPUT_A && encode_enable_in)[*2] |=> cell_output_pin_out)
        else $error("one bit not high at boundary");
    a_half_high_len: assert property ($fell(pulse_out) && arm_r && $stable(period_out) |->
        run_r >= {1'b0, period_out[15:1]}) else $error("pulse high too short");
    a_half_low_len: assert property (!pulse_out && !last_r && arm_r && $stable(period_out) |->
        run_r < period_out - {1'b0, period_out[15:1]}) else $error("pulse low too long");
    a_period_from_cfg: assert property ($past(rst_n_in) && !$past(auto_period_in) |->
        period_out == ($past(bit_time_cfg_in) < `BT_MIN ? `BT_MIN : $past(bit_time_cfg_in)))
        else $error("period not from setting");
    a_ovf_sticky: assert property ($past(measure_overflow_out) && !$past(measure_restart_in) |->
        measure_overflow_out) else $error("overflow flag dropped");
    a_head_stands: assert property (measure_valid_out && !measure_ready_in |=>
        measure_valid_out && $stable(measure_data_out)) else $error("head word moved");
    c_rz_high: cover property ($rose(cell_output_pin_out));
    c_overflow: cover property ($rose(measure_overflow_out));
    c_pop: cover property (measure_valid_out && measure_ready_in);
endmodule
bind nrz_to_rz_encoder nrz_rz_monitor #(.MEAS_DEPTH(MEAS_DEPTH)) mon (
    .clk_in(clk_in), .rst_n_in(rst_n_in), .cell_input_a_in(cell_input_a_in),
    .cell_input_b_in(cell_input_b_in), .src_sel_in(src_sel_in),
    .encode_enable_in(encode_enable_in), .bit_time_cfg_in(bit_time_cfg_in),
    .auto_period_in(auto_period_in), .measure_restart_in(measure_restart_in),
    .cell_output_pin_out(cell_output_pin_out), .pulse_out(pulse_out),
    .period_out(period_out), .measure_valid_out(measure_valid_out),
    .measure_data_out(measure_data_out), .measure_ready_in(measure_ready_in),
    .measure_overflow_out(measure_overflow_out)
);

// ### tb/nrz_source.sv
// Behavioural NRZ source driving one cell input pin.
// Assumes send is called just after a falling clock edge.
module nrz_source (
    // Clock
    input wire logic clk_in,
    // Line
    output logic line_out
);
    timeunit 1ns;
    timeprecision 1ns;
    initial line_out = 1'b0;
    // Most significant bit first; the last level is held after the byte
    task automatic send(input logic [7:0] bits, input int t);
        for (int i = 7; i >= 0; i--) begin
            line_out = bits[i];
            repeat (t) @(negedge clk_in);
        end
    endtask
endmodule

// ### tb/testbench.sv
// Self-checking bench for the NRZ to RZ encoder.
// Assumes the design, the monitor and nrz_source are compiled first.
`include "nrz_rz_defines.svh"
module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    import nrz_rz_pkg::*;
    logic clk, rst_n, en, auto, rstrt, rdy, a, b, q, pls, mv, ovf;
    src_sel_t sel;
    logic [`BT_W-1:0] cfg, per, md;
    int fail_count = 0;
    int comparisons = 0;
    nrz_source src_a (.clk_in(clk), .line_out(a));
    nrz_source src_b (.clk_in(clk), .line_out(b));
    nrz_to_rz_encoder uut (.clk_in(clk), .rst_n_in(rst_n), .cell_input_a_in(a),
        .cell_input_b_in(b), .src_sel_in(sel), .encode_enable_in(en), .bit_time_cfg_in(cfg),
        .auto_period_in(auto), .measure_restart_in(rstrt), .cell_output_pin_out(q),
        .pulse_out(pls), .period_out(per), .measure_valid_out(mv), .measure_data_out(md),
        .measure_ready_in(rdy), .measure_overflow_out(ovf));
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        comparisons++;
        if (got !== exp) begin
            fail_count++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic end_sim;
        if (fail_count == 0 && comparisons > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    task automatic do_reset;
        rst_n = 1'b0;
        repeat (10) @(negedge clk);
        chk({12'h000, q, pls, mv, ovf}, 16'h0000);
        rst_n = 1'b1;
    endtask
    // Line lags the pin by three edges; only a one bit gives a high first half
    task automatic t_encode(input src_sel_t s, input logic e, input logic [15:0] c);
        int t;
        logic [7:0] d;
        t = (c < 16'h0002) ? 2 : int'(c);
        d = 8'hb2;
        sel = s;
        en = e;
        cfg = c;
        repeat (4) @(negedge clk);
        chk(per, t[15:0]);
        fork
            if (s == SRC_INPUT_A) src_a.send(d, t); else src_b.send(d, t);
            for (int i = 0; i < 8 * t; i++) begin
                repeat ((i == 0) ? 3 : 1) @(negedge clk);
                chk({15'h0000, q}, {15'h0000, e & d[7 - i / t] & (i % t < t / 2)});
            end
        join
    endtask
    // Fills past the buffer with the reader stalled, then drains it
    task automatic t_measure;
        int n;
        sel = SRC_INPUT_A;
        cfg = 16'h0004;
        rstrt = 1'b1;
        @(negedge clk);
        rstrt = 1'b0;
        rdy = 1'b0;
        repeat (3) src_a.send(8'haa, 5);
        repeat (4) @(negedge clk);
        chk({15'h0000, ovf}, 16'h0001);
        auto = 1'b1;
        repeat (2) @(negedge clk);
        chk(per, 16'h0005);
        auto = 1'b0;
        rdy = 1'b1;
        n = 0;
        repeat (30) begin
            if (mv === 1'b1) begin
                chk(md, 16'h0005);
                n++;
            end
            @(negedge clk);
        end
        chk(n[15:0], 16'(`MEAS_DEPTH + 2));
        rstrt = 1'b1;
        @(negedge clk);
        rstrt = 1'b0;
        @(negedge clk);
        chk({15'h0000, ovf}, 16'h0000);
    endtask
    initial begin
        rst_n = 1'b0;
        en = 1'b0;
        auto = 1'b0;
        rstrt = 1'b0;
        rdy = 1'b1;
        cfg = 16'h0004;
        sel = SRC_INPUT_A;
        do_reset;
        t_encode(SRC_INPUT_A, 1'b1, 16'h0004);
        t_encode(SRC_INPUT_B, 1'b1, 16'h0006);
        t_encode(SRC_INPUT_A, 1'b1, 16'h0005);
        t_encode(SRC_INPUT_A, 1'b1, 16'h0001);
        t_encode(SRC_INPUT_B, 1'b0, 16'h0004);
        t_measure;
        do_reset;
        t_encode(SRC_INPUT_A, 1'b1, 16'h0004);
        end_sim;
    end
    // Whole run is a few hundred cycles
    initial begin
        #2000000;
        fail_count++;
        end_sim;
    end
endmodule
